// *** flk_cfg.svh ***
`ifndef FLK_CFG_SVH
`define FLK_CFG_SVH

// ****************************************
// command opcodes
// ****************************************
`define FLK_OP_LOCK 8'h36
`define FLK_OP_UNLOCK 8'h39
`define FLK_OP_LOCK_RD 8'h3D
`define FLK_OP_GLB_LOCK 8'h7E
`define FLK_OP_GLB_UNLOCK 8'h98
`define FLK_OP_RST_EN 8'h66
`define FLK_OP_RST 8'h99

// ****************************************
// frame lengths in bits, XIP exit length in link clocks
// ****************************************
`define FLK_OP_BITS 6'h08
`define FLK_ADDR3_BITS 6'h18
`define FLK_ADDR4_BITS 6'h20
`define FLK_RD_BITS 4'h8
`define FLK_XIP_CLKS 4'h8

// ****************************************
// configuration and shipped values
// ****************************************
`define FLK_CFG_ADDR 8'h04
`define FLK_WPS_BIT 2
`define FLK_ERASED_BYTE 8'hFF
`define FLK_STATUS_SHIPPED 8'h00

// ****************************************
// timing
// ****************************************
`define FLK_PCLK_MHZ 125
`define FLK_T_RST_NS 30000
`define FLK_RST_CYC ((`FLK_T_RST_NS * `FLK_PCLK_MHZ + 999) / 1000)
`define FLK_SCLK_HALF 4

// ****************************************
// host controller registers
// ****************************************
`define FLK_REG_CTRL 12'h000
`define FLK_REG_ADDR 12'h004
`define FLK_REG_STAT 12'h008
`define FLK_CTRL_QUAD 8
`define FLK_CTRL_ADDR4 9
`define FLK_CTRL_HAS_ADDR 10
`define FLK_CTRL_READ 11
`define FLK_CTRL_XIP_EXIT 12
`define FLK_CTRL_GO 31
`define FLK_STAT_BUSY 0

`endif

// *** flk_pkg.sv ***
`default_nettype none
package flk_pkg;
  typedef enum logic [2:0] {
    FLK_H_IDLE,
    FLK_H_XIP,
    FLK_H_SEND,
    FLK_H_READ,
    FLK_H_GAP
  } flk_host_state_e;
endpackage
`default_nettype wire

// *** flk_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface flk_if;
  logic cs_n;
  logic sclk;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe_n;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe_n;
  logic [3:0] io;

  // ****************************************
  // wire resolution, undriven lines pulled high
  // ****************************************
  generate
    for (genvar i = 0; i < 4; i++) begin : g_io
      assign io[i] = !h_io_oe_n[i] ? h_io_o[i] : (!d_io_oe_n[i] ? d_io_o[i] : 1'b1);
    end
  endgenerate

  modport host (output cs_n, output sclk, output h_io_o, output h_io_oe_n, input io);
  modport dev (input cs_n, input sclk, input io, output d_io_o, output d_io_oe_n);
endinterface
`default_nettype wire

// *** flk_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module flk_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= INIT;
      q_ff <= INIT;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

// *** flk_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flk_cfg.svh"
module flk_dev #(
  parameter int N_UNITS = 16,
  parameter int UNIT_LSB = 16,
  parameter int RST_CYC = `FLK_RST_CYC
) (
  // system clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  flk_if.dev link,
  // mode and configuration from the surrounding device
  input wire logic [7:0] config_byte,
  input wire logic [4:0] block_protect_bits,
  input wire logic quad_command_format,
  input wire logic four_byte_mode,
  input wire logic execute_in_place_mode,
  // program and erase gate
  input wire logic pe_req,
  input wire logic [31:0] pe_addr,
  output logic pe_grant,
  output logic pe_deny,
  // reset and status
  output logic volatile_clear,
  output logic rst_busy,
  output logic [N_UNITS-1:0] lock_bits,
  output logic [7:0] erased_byte,
  output logic [7:0] status_shipped
);
  localparam int UW = $clog2(N_UNITS);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [5:0] frame_bits(input logic four);
    frame_bits = `FLK_OP_BITS + (four ? `FLK_ADDR4_BITS : `FLK_ADDR3_BITS);
  endfunction

  function automatic logic [UW-1:0] unit_of(input logic [39:0] a);
    unit_of = a[UNIT_LSB +: UW];
  endfunction

  // top 2^(bp-1) units protected when bp is nonzero
  function automatic logic bp_protects(input logic [4:0] bp, input logic [UW-1:0] u);
    logic [31:0] span;
    span = 32'h1 << (bp - 5'h1);
    if (bp == 5'h0) begin
      bp_protects = 1'b0;
    end else if (span >= 32'(N_UNITS)) begin
      bp_protects = 1'b1;
    end else begin
      bp_protects = 32'(u) >= 32'(N_UNITS) - span;
    end
  endfunction

  // ****************************************
  // link domain: frame capture
  // ****************************************
  // mode inputs and lock_ff are quasi-static: they only change between frames
  logic [5:0] cnt_ff;
  logic [5:0] len_ff;
  logic [39:0] fr_ff;
  logic [7:0] op_ff;
  logic [7:0] dout_ff;
  logic rd_ff;
  logic turn_ff;
  logic [39:0] nxt_fr;
  logic [5:0] nxt_cnt;
  logic [N_UNITS-1:0] lock_ff;
  logic rec_l;

  // recovery flag retimed onto the link clock
  flk_sync #(.W(1), .INIT(1'b0)) u_rec_sync (
    .clk(link.sclk), .rst_n(presetn), .d(rst_busy), .q(rec_l)
  );

  always_comb begin
    nxt_fr = quad_command_format ? {fr_ff[35:0], link.io} : {fr_ff[38:0], link.io[0]};
    nxt_cnt = cnt_ff + (quad_command_format ? 6'h04 : 6'h01);
  end

  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt_ff <= 6'h00;
    end else if (cnt_ff <= frame_bits(four_byte_mode)) begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      fr_ff <= 40'h0;
      len_ff <= 6'h00;
      op_ff <= 8'h00;
    end else if (!link.cs_n && cnt_ff <= frame_bits(four_byte_mode)) begin
      len_ff <= nxt_cnt;
      if (cnt_ff < frame_bits(four_byte_mode)) begin
        fr_ff <= nxt_fr;
      end
      if (nxt_cnt == `FLK_OP_BITS) begin
        op_ff <= nxt_fr[7:0];
      end
    end
  end

  // lock status byte, loaded on the edge that takes the last address bit; quad mode drives it one clock later
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      rd_ff <= 1'b0;
      turn_ff <= 1'b0;
      dout_ff <= 8'h00;
    end else if (cnt_ff < frame_bits(four_byte_mode) && op_ff == `FLK_OP_LOCK_RD
                 && nxt_cnt == frame_bits(four_byte_mode) && !rec_l) begin
      rd_ff <= 1'b1;
      turn_ff <= quad_command_format;
      dout_ff <= {7'h00, lock_ff[unit_of(nxt_fr)]};
    end else if (rd_ff && turn_ff) begin
      turn_ff <= 1'b0;
    end else if (rd_ff) begin
      dout_ff <= quad_command_format ? {dout_ff[3:0], 4'h0} : {dout_ff[6:0], 1'b0};
    end
  end

  always_comb begin
    link.d_io_o = quad_command_format ? dout_ff[7:4] : {2'b00, dout_ff[7], 1'b0};
    link.d_io_oe_n = 4'hF;
    if (rd_ff && !turn_ff) begin
      link.d_io_oe_n = quad_command_format ? 4'h0 : 4'hD;
    end
  end

  // ****************************************
  // system domain: frame end decode
  // ****************************************
  logic cs_s;
  logic cs_prev_ff;
  logic frame_end;
  logic arm_ff;
  logic [$clog2(RST_CYC+1)-1:0] rst_cnt_ff;
  logic len_op;
  logic len_addr;
  logic go;

  flk_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.cs_n),
    .q(cs_s)
  );

  // capture registers hold still from cs rise until the next frame's first edge
  always_comb begin
    frame_end = cs_s && !cs_prev_ff;
    len_op = len_ff == `FLK_OP_BITS;
    len_addr = len_ff == frame_bits(four_byte_mode);
    go = frame_end && rst_cnt_ff == '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_prev_ff <= 1'b1;
    end else begin
      cs_prev_ff <= cs_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_ff <= '0;
    end else if (go && len_addr && op_ff == `FLK_OP_LOCK) begin
      lock_ff[unit_of(fr_ff)] <= 1'b1;
    end else if (go && len_addr && op_ff == `FLK_OP_UNLOCK) begin
      lock_ff[unit_of(fr_ff)] <= 1'b0;
    end else if (go && len_op && op_ff == `FLK_OP_GLB_LOCK) begin
      lock_ff <= '1;
    end else if (go && len_op && op_ff == `FLK_OP_GLB_UNLOCK) begin
      lock_ff <= '0;
    end else if (volatile_clear) begin
      lock_ff <= '0;
    end
  end

  // enable arms only the very next frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff <= 1'b0;
    end else if (go) begin
      arm_ff <= len_op && op_ff == `FLK_OP_RST_EN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volatile_clear <= 1'b0;
      rst_cnt_ff <= '0;
    end else if (go && arm_ff && len_op && op_ff == `FLK_OP_RST && !execute_in_place_mode) begin
      volatile_clear <= 1'b1;
      rst_cnt_ff <= ($clog2(RST_CYC+1))'(RST_CYC);
    end else begin
      volatile_clear <= 1'b0;
      if (rst_cnt_ff != '0) begin
        rst_cnt_ff <= rst_cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_busy <= 1'b0;
    end else begin
      rst_busy <= volatile_clear || rst_cnt_ff > 1;
    end
  end

  // ****************************************
  // program and erase gate
  // ****************************************
  logic prot;

  always_comb begin
    if (config_byte[`FLK_WPS_BIT]) begin
      prot = bp_protects(block_protect_bits, unit_of({8'h00, pe_addr}));
    end else begin
      prot = lock_ff[unit_of({8'h00, pe_addr})];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pe_grant <= 1'b0;
      pe_deny <= 1'b0;
    end else begin
      pe_grant <= pe_req && !prot && rst_cnt_ff == '0;
      pe_deny <= pe_req && (prot || rst_cnt_ff != '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_bits <= '0;
      erased_byte <= `FLK_ERASED_BYTE;
      status_shipped <= `FLK_STATUS_SHIPPED;
    end else begin
      lock_bits <= lock_ff;
      erased_byte <= `FLK_ERASED_BYTE;
      status_shipped <= `FLK_STATUS_SHIPPED;
    end
  end
endmodule
`default_nettype wire

// *** flk_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flk_cfg.svh"
module flk_host #(
  parameter int HALF = `FLK_SCLK_HALF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  flk_if.host link
);
  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_ff;
  logic [31:0] addr_ff;
  logic [7:0] rdat_ff;
  logic go_ff;
  logic busy;
  logic wr_hit;
  flk_pkg::flk_host_state_e st_ff;

  assign busy = st_ff != flk_pkg::FLK_H_IDLE || go_ff;
  assign wr_hit = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 32'h0;
      addr_ff <= 32'h0;
      go_ff <= 1'b0;
    end else begin
      go_ff <= go_ff && st_ff != flk_pkg::FLK_H_IDLE;
      if (wr_hit && paddr == `FLK_REG_CTRL && !busy) begin
        ctrl_ff <= pwdata;
        go_ff <= pwdata[`FLK_CTRL_GO];
      end
      if (wr_hit && paddr == `FLK_REG_ADDR && !busy) begin
        addr_ff <= pwdata;
      end
    end
  end

  // answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != `FLK_REG_CTRL && paddr != `FLK_REG_ADDR
                 && paddr != `FLK_REG_STAT;
      prdata <= 32'h0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `FLK_REG_CTRL: prdata <= ctrl_ff;
          `FLK_REG_ADDR: prdata <= addr_ff;
          `FLK_REG_STAT: prdata <= {16'h0, rdat_ff, 7'h0, busy};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************
  // link clock divider and sequencer
  // ****************************************
  logic [3:0] io_s;
  logic [$clog2(HALF)-1:0] div_ff;
  logic tick;
  logic rise;
  logic fall;
  logic quad;
  logic [39:0] sh_ff;
  logic [5:0] cnt_ff;
  logic [5:0] nbits;
  logic [3:0] rcnt_ff;

  flk_sync #(.W(4), .INIT(4'hF)) u_io_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.io),
    .q(io_s)
  );

  always_comb begin
    quad = ctrl_ff[`FLK_CTRL_QUAD];
    tick = div_ff == ($clog2(HALF))'(HALF - 1);
    rise = tick && !link.sclk;
    fall = tick && link.sclk;
    nbits = `FLK_OP_BITS;
    if (ctrl_ff[`FLK_CTRL_HAS_ADDR]) begin
      nbits = `FLK_OP_BITS + (ctrl_ff[`FLK_CTRL_ADDR4] ? `FLK_ADDR4_BITS : `FLK_ADDR3_BITS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
    end else if (st_ff == flk_pkg::FLK_H_IDLE || tick) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= flk_pkg::FLK_H_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.h_io_o <= 4'h0;
      link.h_io_oe_n <= 4'hF;
      sh_ff <= 40'h0;
      cnt_ff <= 6'h00;
      rcnt_ff <= 4'h0;
      rdat_ff <= 8'h00;
    end else begin
      if (tick && st_ff != flk_pkg::FLK_H_GAP) begin
        link.sclk <= !link.sclk;
      end
      case (st_ff)
        flk_pkg::FLK_H_IDLE: begin
          cnt_ff <= 6'h00;
          rcnt_ff <= 4'h0;
          if (go_ff && ctrl_ff[`FLK_CTRL_XIP_EXIT]) begin
            link.h_io_o <= 4'hF;
            link.h_io_oe_n <= 4'h0;
            st_ff <= flk_pkg::FLK_H_XIP;
          end else if (go_ff) begin
            sh_ff <= ctrl_ff[`FLK_CTRL_ADDR4] ? {ctrl_ff[7:0], addr_ff} :
                     {ctrl_ff[7:0], addr_ff[23:0], 8'h00};
            link.cs_n <= 1'b0;
            link.h_io_o <= quad ? ctrl_ff[7:4] : {3'b111, ctrl_ff[7]};
            link.h_io_oe_n <= quad ? 4'h0 : 4'hE;
            st_ff <= flk_pkg::FLK_H_SEND;
          end
        end
        flk_pkg::FLK_H_XIP: begin
          if (rise) begin
            rcnt_ff <= rcnt_ff + 4'h1;
          end
          if (fall && rcnt_ff == `FLK_XIP_CLKS) begin
            link.h_io_oe_n <= 4'hF;
            st_ff <= flk_pkg::FLK_H_GAP;
          end
        end
        flk_pkg::FLK_H_SEND: begin
          if (rise) begin
            cnt_ff <= cnt_ff + (quad ? 6'h04 : 6'h01);
          end
          if (fall && cnt_ff == nbits) begin
            link.h_io_oe_n <= 4'hF;
            if (ctrl_ff[`FLK_CTRL_READ]) begin
              st_ff <= flk_pkg::FLK_H_READ;
            end else begin
              link.cs_n <= 1'b1;
              st_ff <= flk_pkg::FLK_H_GAP;
            end
          end else if (fall) begin
            sh_ff <= quad ? {sh_ff[35:0], 4'h0} : {sh_ff[38:0], 1'b0};
            link.h_io_o <= quad ? sh_ff[35:32] : {3'b111, sh_ff[38]};
          end
        end
        flk_pkg::FLK_H_READ: begin
          // quad read spends one clock on turnaround
          if (rise) begin
            rcnt_ff <= rcnt_ff + 4'h1;
            if (quad && rcnt_ff != 4'h0) begin
              rdat_ff <= {rdat_ff[3:0], io_s};
            end else if (!quad) begin
              rdat_ff <= {rdat_ff[6:0], io_s[1]};
            end
          end
          if (fall && rcnt_ff == (quad ? 4'h3 : `FLK_RD_BITS)) begin
            link.cs_n <= 1'b1;
            st_ff <= flk_pkg::FLK_H_GAP;
          end
        end
        flk_pkg::FLK_H_GAP: begin
          link.sclk <= 1'b0;
          if (tick) begin
            st_ff <= flk_pkg::FLK_H_IDLE;
          end
        end
        default: st_ff <= flk_pkg::FLK_H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** flk_link_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module flk_link_assertions (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe_n,
  input wire logic [3:0] d_io_oe_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************
  // framing and clocking
  // ****************************************
  chk_frame_start_low: assert property ($fell(cs_n) |-> !sclk && !h_io_oe_n[0])
    else $error("frame does not start with link clock low and host driving");
  chk_sclk_high_len: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("link clock high phase has wrong length");
  chk_sclk_low_len: assert property ($fell(sclk) |-> (!sclk)[*4])
    else $error("link clock low phase too short");
  chk_host_data_hold: assert property (sclk && $past(sclk) |-> $stable(h_io_o))
    else $error("host data changed while link clock high");
  chk_frame_gap_len: assert property ($rose(cs_n) |-> cs_n[*4])
    else $error("chip select gap between frames too short");

  // ****************************************
  // device drive
  // ****************************************
  chk_no_drive_fight: assert property ((h_io_oe_n | d_io_oe_n) == 4'hF)
    else $error("host and device drive a line together");
  chk_dev_release_idle: assert property (cs_n[*5] |-> d_io_oe_n == 4'hF)
    else $error("device drives a line while deselected");
  chk_dev_quiet_start: assert property ($fell(cs_n) |-> d_io_oe_n == 4'hF)
    else $error("device drives at frame start");

  cov_frame: cover property ($fell(cs_n));
  cov_dev_answer: cover property (d_io_oe_n != 4'hF);
  cov_quad_send: cover property (!cs_n && h_io_oe_n == 4'h0);
endmodule
`default_nettype wire

// *** test_flash_lock_and_reset_commands.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "flk_cfg.svh"
module test_flash_lock_and_reset_commands;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pe_addr;
  logic [7:0] config_byte, erased_byte, status_shipped, b;
  logic [4:0] block_protect_bits;
  logic quad_command_format, four_byte_mode, execute_in_place_mode;
  logic pe_req, pe_grant, pe_deny, volatile_clear, rst_busy, q, a4;
  logic [15:0] lock_bits;
  int num_errors, samples_checked, vc_n;

  flk_if i_flk_if();
  flk_host i_flk_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(i_flk_if));
  flk_dev #(.RST_CYC(200)) i_flk_dev (.pclk(pclk), .presetn(presetn), .link(i_flk_if),
    .config_byte(config_byte), .block_protect_bits(block_protect_bits),
    .quad_command_format(quad_command_format), .four_byte_mode(four_byte_mode),
    .execute_in_place_mode(execute_in_place_mode), .pe_req(pe_req), .pe_addr(pe_addr),
    .pe_grant(pe_grant), .pe_deny(pe_deny), .volatile_clear(volatile_clear),
    .rst_busy(rst_busy), .lock_bits(lock_bits), .erased_byte(erased_byte),
    .status_shipped(status_shipped));
  flk_link_assertions i_flk_link_assertions (.pclk(pclk), .presetn(presetn),
    .cs_n(i_flk_if.cs_n), .sclk(i_flk_if.sclk), .h_io_o(i_flk_if.h_io_o),
    .h_io_oe_n(i_flk_if.h_io_oe_n), .d_io_oe_n(i_flk_if.d_io_oe_n));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (volatile_clear === 1'b1) vc_n++;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic wrap_up;
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) num_errors++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [2:0] f, input logic [31:0] a);
    logic [31:0] r;
    logic e;
    int n;
    apb(1'b1, `FLK_REG_ADDR, a, r, e);
    apb(1'b1, `FLK_REG_CTRL, {1'b1, 18'h00000, f, a4, q, op}, r, e);
    n = 0;
    do begin
      apb(1'b0, `FLK_REG_STAT, 32'h00000000, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 500);
    if (n >= 500) num_errors++;
    b = r[15:8];
    repeat (8) @(posedge pclk);
  endtask

  task automatic pe(input logic [3:0] u, input logic deny);
    pe_addr <= {12'h000, u, 16'h0000};
    pe_req <= 1'b1;
    @(posedge pclk);
    pe_req <= 1'b0;
    @(posedge pclk);
    chk("pe_grant", pe_grant, !deny);
    chk("pe_deny", pe_deny, deny);
    @(posedge pclk);
  endtask

  task automatic rst_pair;
    chk("pe_idle", pe_grant, 1'b0);
    cmd(8'h66, 3'h0, 32'h00000000);
    cmd(8'h99, 3'h0, 32'h00000000);
  endtask

  task automatic wait_rec;
    int n;
    n = 0;
    while (rst_busy !== 1'b0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 1000) num_errors++;
  endtask

  // ****************************************
  // watchdog and main sequence
  // ****************************************
  initial begin
    #400000;
    num_errors++;
    wrap_up;
  end

  initial begin
    logic [31:0] r, ad;
    logic e;
    logic [3:0] u;
    {presetn, psel, penable, pwrite, pe_req, execute_in_place_mode} = 6'h00;
    {quad_command_format, four_byte_mode, q, a4} = 4'h0;
    {paddr, pwdata, pe_addr, config_byte, block_protect_bits} = '0;
    {num_errors, samples_checked, vc_n} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("erased_byte", erased_byte, 8'hFF);
    chk("status_shipped", status_shipped, 8'h00);
    apb(1'b0, 12'h00C, 32'h00000000, r, e);
    chk("pslverr", e, 1'b1);
    chk("prdata", r, 32'h00000000);
    for (int m = 0; m < 4; m++) begin
      q = m[0];
      a4 = m[1];
      quad_command_format <= q;
      four_byte_mode <= a4;
      u = 4'(m * 5);
      ad = {(a4 ? 8'hA5 : 8'h00), 4'h0, u, 16'h1234};
      cmd(8'h36, 3'h1, ad);
      chk("lock_set", lock_bits[u], 1'b1);
      cmd(8'h3D, 3'h3, ad);
      chk("lock_read", b, 8'h01);
      cmd(8'h39, 3'h1, ad);
      chk("lock_clr", lock_bits, 16'h0000);
      cmd(8'h3D, 3'h3, ad);
      chk("unlock_read", b, 8'h00);
    end
    q = 1'b0;
    quad_command_format <= 1'b0;
    four_byte_mode <= 1'b0;
    cmd(8'h36, 3'h1, 32'h00030000);
    chk("long_addr", lock_bits, 16'h0000);
    a4 = 1'b0;
    cmd(8'h7E, 3'h0, 32'h00000000);
    chk("glb_lock", lock_bits, 16'hFFFF);
    pe(4'h3, 1'b1);
    cmd(8'h98, 3'h0, 32'h00000000);
    chk("glb_unlock", lock_bits, 16'h0000);
    pe(4'h3, 1'b0);
    config_byte <= 8'h04;
    cmd(8'h7E, 3'h0, 32'h00000000);
    pe(4'h3, 1'b0);
    block_protect_bits <= 5'h01;
    pe(4'hF, 1'b1);
    pe(4'hE, 1'b0);
    config_byte <= 8'h00;
    block_protect_bits <= 5'h00;
    cmd(8'h99, 3'h0, 32'h00000000);
    cmd(8'h66, 3'h0, 32'h00000000);
    cmd(8'h7E, 3'h0, 32'h00000000);
    cmd(8'h99, 3'h0, 32'h00000000);
    chk("unarmed_rst", vc_n, 0);
    chk("unarmed_locks", lock_bits, 16'hFFFF);
    for (int m = 0; m < 2; m++) begin
      q = m[0];
      quad_command_format <= q;
      cmd(8'h7E, 3'h0, 32'h00000000);
      rst_pair();
      chk("rst_count", vc_n, m + 1);
      chk("rst_busy", rst_busy, 1'b1);
      chk("rst_locks", lock_bits, 16'h0000);
      cmd(8'h7E, 3'h0, 32'h00000000);
      wait_rec();
      chk("rec_ignored", lock_bits, 16'h0000);
    end
    execute_in_place_mode <= 1'b1;
    rst_pair();
    chk("xip_rst", vc_n, 2);
    cmd(8'h00, 3'h4, 32'h00000000);
    execute_in_place_mode <= 1'b0;
    rst_pair();
    wait_rec();
    q = 1'b0;
    quad_command_format <= 1'b0;
    rst_pair();
    wait_rec();
    chk("exit_rst", vc_n, 4);
    wrap_up;
  end
endmodule
`default_nettype wire
